// file: design/dspam_pkg.sv
// Notes on behaviour
// - Control bit 7 is mode bit or sticky stop-bit error, per error_flag_select.
// - Two mode bits pick shift mode 0 or asynchronous 10/11-bit modes 1..3.
// - Modes 2/3 with filter on: no rx_done_flag when ninth bit is 0.
// - Mode 1 with filter on: rx_done_flag only after a valid stop bit.
// - Mode 0: filter bit picks shift clock, clock/12 or clock/4.
// - Reception starts only while rx_enable is 1; a mode 0 frame once begun runs to its end.
// - Modes 2/3 send tx_ninth_bit as ninth data bit.
// - rx_ninth_bit holds ninth bit (modes 2/3) or stop bit (mode 1, filter off).
// - tx_done_flag set after 8th bit (mode 0) or at stop start; software clears.
// - rx_done_flag set after 8th bit (mode 0) or mid stop bit; software clears.
// - Buffer address reads receive register, write loads transmit buffer and starts.
// - Port 0 compares address bits only where match_mask_0 bit is 1.
// - All-zero match_mask_0 accepts any address.
// - Port 1 behaves like port 0 with its own registers, except that its modes 1/3 always take rates from timer 1.
// - Port 1 matches against match_address_1 under match_mask_1; zero mask accepts all.
// - Port 0 transmits on tx_line_0, receives on rx_line_0.
// - Port 0 modes 1/3 take rates from timer 1 or timer 2 overflow.
// - Port 1 receives on rx_line_1 and transmits on tx_line_1.
package dspam_pkg;
  // ----------------------------------------
  // Register indices, byte address is four times
  // ----------------------------------------
  localparam logic [7:0] IDX_CTRL0 = 8'h98;
  localparam logic [7:0] IDX_BUF0 = 8'h99;
  localparam logic [7:0] IDX_MASK0 = 8'hb9;
  localparam logic [7:0] IDX_CTRL1 = 8'hc0;
  localparam logic [7:0] IDX_BUF1 = 8'hc1;
  localparam logic [7:0] IDX_ADDR0 = 8'ha9;
  localparam logic [7:0] IDX_ADDR1 = 8'haa;
  localparam logic [7:0] IDX_MASK1 = 8'hba;
  localparam logic [7:0] IDX_PWR = 8'h87;
  localparam logic [7:0] IDX_BSRC = 8'hc8;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PWR_DOUBLE_BIT = 7;
  localparam int PWR_EFS_BIT = 6;
  localparam int BSRC_RX_BIT = 5;
  localparam int BSRC_TX_BIT = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------
  // Timing counts in clocks, and in sixteenth-bit ticks for OVS_LAST/OVS_MID
  // ----------------------------------------
  localparam logic [3:0] M0_DIV_SLOW = 4'd12;
  localparam logic [3:0] M0_DIV_FAST = 4'd4;
  localparam logic [3:0] M2_PRE_SLOW = 4'd4;
  localparam logic [3:0] M2_PRE_FAST = 4'd2;
  localparam logic [3:0] OVS_LAST = 4'd15;
  localparam logic [3:0] OVS_MID = 4'd7;
  typedef enum logic [2:0] {
    DSPAM_TX_IDLE = 3'b001,
    DSPAM_TX_SHIFT = 3'b010,
    DSPAM_TX_STOP = 3'b100
  } dspam_tx_t;
  typedef enum logic [3:0] {
    DSPAM_RX_IDLE = 4'b0001,
    DSPAM_RX_START = 4'b0010,
    DSPAM_RX_DATA = 4'b0100,
    DSPAM_RX_STOP = 4'b1000
  } dspam_rx_t;
endpackage

// file: design/dspam_top.sv
`timescale 1ns/1ps
module dspam_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Baud sources
  input wire logic timer1_ovf_i,
  input wire logic timer2_ovf_i,
  // Port 0 lines
  output logic tx_line_0_o,
  input wire logic rx_line_0_i,
  output logic rx_line_0_o,
  output logic rx_line_0_oe_o,
  // Port 1 lines
  output logic tx_line_1_o,
  input wire logic rx_line_1_i,
  output logic rx_line_1_o,
  output logic rx_line_1_oe_o
);
  import dspam_pkg::*;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_en;
  logic [7:0] idx;
  logic [7:0] rd_mux;
  logic dbl_q;
  logic efs_q;
  logic rxsrc_q;
  logic txsrc_q;
  logic [7:0] ctl_rd [2];
  logic [7:0] buf_rd [2];
  logic [7:0] adr_rd [2];
  logic [7:0] msk_rd [2];
  logic [1:0] rx_pin;
  logic [1:0] tx_pin_o;
  logic [1:0] rx_pin_o;
  logic [1:0] rx_pin_oe;

  assign req = avs_read_i | avs_write_i;
  assign idx = avs_address_i[9:2];
  // One wait cycle: decode first, act at the edge where waitrequest is low
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_en = avs_write_i & ack_q & avs_byteenable_i[0];
  assign avs_readdata_o = rdata_q;

  always_comb begin
    case (idx)
      IDX_CTRL0: rd_mux = ctl_rd[0];
      IDX_BUF0: rd_mux = buf_rd[0];
      IDX_ADDR0: rd_mux = adr_rd[0];
      IDX_MASK0: rd_mux = msk_rd[0];
      IDX_CTRL1: rd_mux = ctl_rd[1];
      IDX_BUF1: rd_mux = buf_rd[1];
      IDX_ADDR1: rd_mux = adr_rd[1];
      IDX_MASK1: rd_mux = msk_rd[1];
      IDX_PWR: rd_mux = {dbl_q, efs_q, 6'h00};
      IDX_BSRC: rd_mux = {2'b00, rxsrc_q, txsrc_q, 4'h0};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read_i & ~ack_q) begin
        rdata_q <= {24'h0, rd_mux};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbl_q <= 1'b0;
      efs_q <= 1'b0;
      rxsrc_q <= 1'b0;
      txsrc_q <= 1'b0;
    end else if (wr_en && idx == IDX_PWR) begin
      dbl_q <= avs_writedata_i[PWR_DOUBLE_BIT];
      efs_q <= avs_writedata_i[PWR_EFS_BIT];
    end else if (wr_en && idx == IDX_BSRC) begin
      rxsrc_q <= avs_writedata_i[BSRC_RX_BIT];
      txsrc_q <= avs_writedata_i[BSRC_TX_BIT];
    end
  end

  // ----------------------------------------
  // Pin mapping
  // ----------------------------------------
  assign rx_pin = {rx_line_1_i, rx_line_0_i};
  assign tx_line_0_o = tx_pin_o[0];
  assign rx_line_0_o = rx_pin_o[0];
  assign rx_line_0_oe_o = rx_pin_oe[0];
  assign tx_line_1_o = tx_pin_o[1];
  assign rx_line_1_o = rx_pin_o[1];
  assign rx_line_1_oe_o = rx_pin_oe[1];

  // ----------------------------------------
  // Serial ports
  // ----------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_port
    localparam logic [7:0] C_CTL = (g == 0) ? IDX_CTRL0 : IDX_CTRL1;
    localparam logic [7:0] C_BUF = (g == 0) ? IDX_BUF0 : IDX_BUF1;
    localparam logic [7:0] C_ADR = (g == 0) ? IDX_ADDR0 : IDX_ADDR1;
    localparam logic [7:0] C_MSK = (g == 0) ? IDX_MASK0 : IDX_MASK1;
    logic sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, fe_q;
    logic [7:0] rbuf_q, tbuf_q, naddr_q, mask_q;
    logic pend_q;
    logic [1:0] mode;
    logic w_ctl, w_buf;
    logic ti_set, ri_set, fe_set, rb8_ld, rb8_val;
    logic [7:0] rbuf_val;
    logic [3:0] pre_q, lim;
    logic pre_tick;
    logic tovf, rovf, thv_q, rhv_q, tt16, rt16, ttick, rtick;
    logic s1_q, s2_q, prev_q;
    dspam_tx_t tst_q;
    logic [10:0] tsh_q;
    logic [3:0] tsub_q, tbit_q;
    logic m0_q, m0rx_q, txo_q;
    dspam_rx_t rst_q;
    logic [8:0] rsh_q;
    logic [3:0] rsub_q, rbit_q;
    logic stop_ok, ninth, match, accept;
    logic [7:0] rdat;

    assign mode = {sm0_q, sm1_q};
    assign w_ctl = wr_en && idx == C_CTL;
    assign w_buf = wr_en && idx == C_BUF;
    assign ctl_rd[g] = {efs_q ? fe_q : sm0_q, sm1_q, sm2_q, ren_q,
                        tb8_q, rb8_q, ti_q, ri_q};
    assign buf_rd[g] = rbuf_q;
    assign adr_rd[g] = naddr_q;
    assign msk_rd[g] = mask_q;

    // ----------------------------------------
    // Control register, hardware set wins over software clear
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        {sm0_q, sm1_q, sm2_q, ren_q, tb8_q} <= 5'h00;
      end else if (w_ctl) begin
        if (!efs_q) begin
          sm0_q <= avs_writedata_i[7];
        end
        {sm1_q, sm2_q, ren_q, tb8_q} <= avs_writedata_i[6:3];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        {fe_q, rb8_q, ti_q, ri_q} <= 4'h0;
      end else begin
        fe_q <= fe_set | ((w_ctl & efs_q) ? avs_writedata_i[7] : fe_q);
        ti_q <= ti_set | (w_ctl ? avs_writedata_i[1] : ti_q);
        ri_q <= ri_set | (w_ctl ? avs_writedata_i[0] : ri_q);
        if (rb8_ld) begin
          rb8_q <= rb8_val;
        end else if (w_ctl) begin
          rb8_q <= avs_writedata_i[2];
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        naddr_q <= REG_RESET;
        mask_q <= REG_RESET;
        rbuf_q <= REG_RESET;
      end else begin
        if (wr_en && idx == C_ADR) begin
          naddr_q <= avs_writedata_i[7:0];
        end
        if (wr_en && idx == C_MSK) begin
          mask_q <= avs_writedata_i[7:0];
        end
        if (ri_set) begin
          rbuf_q <= rbuf_val;
        end
      end
    end

    // ----------------------------------------
    // Bit timing
    // ----------------------------------------
    // Mode 0 counts whole bits, mode 2 counts sixteenths of a bit
    always_comb begin
      if (mode == 2'b00) begin
        lim = sm2_q ? M0_DIV_FAST : M0_DIV_SLOW;
      end else begin
        lim = dbl_q ? M2_PRE_FAST : M2_PRE_SLOW;
      end
    end
    assign pre_tick = pre_q == lim - 4'd1;

    always_ff @(posedge clk_i) begin
      if (rst_i || pre_tick || (tst_q == DSPAM_TX_IDLE && mode == 2'b00)) begin
        pre_q <= 4'h0;
      end else begin
        pre_q <= pre_q + 4'd1;
      end
    end

    // Port 1 has no timer 2 path, so its variable rate comes from timer 1
    assign tovf = (g == 0 && txsrc_q) ? timer2_ovf_i : timer1_ovf_i;
    assign rovf = (g == 0 && rxsrc_q) ? timer2_ovf_i : timer1_ovf_i;
    assign tt16 = tovf & (dbl_q | thv_q);
    assign rt16 = rovf & (dbl_q | rhv_q);
    assign ttick = (mode == 2'b10) ? pre_tick : tt16;
    assign rtick = (mode == 2'b10) ? pre_tick : rt16;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        thv_q <= 1'b0;
        rhv_q <= 1'b0;
      end else begin
        thv_q <= thv_q ^ tovf;
        rhv_q <= rhv_q ^ rovf;
      end
    end

    // ----------------------------------------
    // Transmit and mode 0 shifter
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pend_q <= 1'b0;
        tbuf_q <= REG_RESET;
      end else if (w_buf) begin
        pend_q <= 1'b1;
        tbuf_q <= avs_writedata_i[7:0];
      end else if (tst_q == DSPAM_TX_IDLE) begin
        pend_q <= 1'b0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tst_q <= DSPAM_TX_IDLE;
        tsh_q <= 11'h7ff;
        tsub_q <= 4'h0;
        tbit_q <= 4'h0;
        m0_q <= 1'b0;
        m0rx_q <= 1'b0;
      end else begin
        case (tst_q)
          DSPAM_TX_IDLE: begin
            tsub_q <= 4'h0;
            tbit_q <= 4'h0;
            m0_q <= mode == 2'b00;
            if (pend_q) begin
              m0rx_q <= 1'b0;
              tst_q <= DSPAM_TX_SHIFT;
              if (mode == 2'b00) begin
                tsh_q <= {3'h7, tbuf_q};
              end else begin
                tsh_q <= {1'b1, mode[0] & ~mode[1] | tb8_q, tbuf_q, 1'b0};
              end
            end else if (mode == 2'b00 && ren_q && !ri_q) begin
              m0rx_q <= 1'b1;
              tst_q <= DSPAM_TX_SHIFT;
            end
          end
          DSPAM_TX_SHIFT: begin
            if (m0_q) begin
              if (pre_tick) begin
                // Receive fills the low byte from the top, so bit 0 ends up lowest
                if (m0rx_q) begin
                  tsh_q <= {3'h7, s2_q, tsh_q[7:1]};
                end else begin
                  tsh_q <= {1'b1, tsh_q[10:1]};
                end
                tbit_q <= tbit_q + 4'd1;
                if (tbit_q == 4'd7) begin
                  tst_q <= DSPAM_TX_IDLE;
                end
              end
            end else if (ttick) begin
              tsub_q <= tsub_q + 4'd1;
              if (tsub_q == OVS_LAST) begin
                tsh_q <= {1'b1, tsh_q[10:1]};
                tbit_q <= tbit_q + 4'd1;
                if (tbit_q == (mode == 2'b01 ? 4'd8 : 4'd9)) begin
                  tst_q <= DSPAM_TX_STOP;
                end
              end
            end
          end
          DSPAM_TX_STOP: begin
            if (ttick) begin
              tsub_q <= tsub_q + 4'd1;
              if (tsub_q == OVS_LAST) begin
                tst_q <= DSPAM_TX_IDLE;
              end
            end
          end
          default: tst_q <= DSPAM_TX_IDLE;
        endcase
      end
    end

    // Stop-bit start for async; end of eighth bit for mode 0 transmit
    assign ti_set = (m0_q && !m0rx_q && tst_q == DSPAM_TX_SHIFT && pre_tick
                     && tbit_q == 4'd7)
                  || (!m0_q && tst_q == DSPAM_TX_SHIFT && ttick && tsub_q == OVS_LAST
                     && tbit_q == (mode == 2'b01 ? 4'd8 : 4'd9));

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        txo_q <= 1'b1;
      end else if (m0_q) begin
        txo_q <= !(tst_q == DSPAM_TX_SHIFT) || pre_q >= (lim >> 1);
      end else begin
        txo_q <= (tst_q == DSPAM_TX_SHIFT) ? tsh_q[0] : 1'b1;
      end
    end

    assign tx_pin_o[g] = txo_q;
    assign rx_pin_o[g] = tsh_q[0];
    assign rx_pin_oe[g] = m0_q && !m0rx_q && tst_q == DSPAM_TX_SHIFT;

    // ----------------------------------------
    // Receive line synchroniser
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        prev_q <= 1'b1;
      end else begin
        s1_q <= rx_pin[g];
        s2_q <= s1_q;
        prev_q <= s2_q;
      end
    end

    // ----------------------------------------
    // Asynchronous receiver
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rst_q <= DSPAM_RX_IDLE;
        rsh_q <= 9'h000;
        rsub_q <= 4'h0;
        rbit_q <= 4'h0;
      end else if (!ren_q || mode == 2'b00) begin
        rst_q <= DSPAM_RX_IDLE;
        rsub_q <= 4'h0;
      end else begin
        case (rst_q)
          DSPAM_RX_IDLE: begin
            rsub_q <= 4'h0;
            rbit_q <= 4'h0;
            if (prev_q && !s2_q) begin
              rst_q <= DSPAM_RX_START;
            end
          end
          DSPAM_RX_START: begin
            if (rtick) begin
              rsub_q <= rsub_q + 4'd1;
              if (rsub_q == OVS_MID) begin
                rsub_q <= 4'h0;
                // A start bit gone high by mid-bit was a glitch
                rst_q <= s2_q ? DSPAM_RX_IDLE : DSPAM_RX_DATA;
              end
            end
          end
          DSPAM_RX_DATA: begin
            if (rtick) begin
              rsub_q <= rsub_q + 4'd1;
              if (rsub_q == OVS_LAST) begin
                rsh_q <= {s2_q, rsh_q[8:1]};
                rbit_q <= rbit_q + 4'd1;
                if (rbit_q == (mode == 2'b01 ? 4'd7 : 4'd8)) begin
                  rst_q <= DSPAM_RX_STOP;
                end
              end
            end
          end
          DSPAM_RX_STOP: begin
            if (rtick) begin
              rsub_q <= rsub_q + 4'd1;
              if (rsub_q == OVS_LAST) begin
                rst_q <= DSPAM_RX_IDLE;
              end
            end
          end
          default: rst_q <= DSPAM_RX_IDLE;
        endcase
      end
    end

    // ----------------------------------------
    // Frame acceptance
    // ----------------------------------------
    assign stop_ok = s2_q;
    assign rdat = (mode == 2'b01) ? rsh_q[8:1] : rsh_q[7:0];
    assign ninth = (mode == 2'b01) ? stop_ok : rsh_q[8];
    assign match = ((rdat ^ naddr_q) & mask_q) == 8'h00;
    always_comb begin
      if (!sm2_q) begin
        accept = 1'b1;
      end else if (mode == 2'b01) begin
        accept = stop_ok;
      end else begin
        accept = ninth & match;
      end
    end

    logic stop_mid, m0_done;
    assign stop_mid = rst_q == DSPAM_RX_STOP && rtick && rsub_q == OVS_LAST
                      && ren_q && mode != 2'b00;
    assign m0_done = m0_q && m0rx_q && tst_q == DSPAM_TX_SHIFT && pre_tick
                     && tbit_q == 4'd7;
    // An unread frame is kept; a newer one is dropped while rx_done_flag is set
    assign ri_set = !ri_q && ((stop_mid && accept) || m0_done);
    assign fe_set = stop_mid && !stop_ok;
    assign rb8_ld = !ri_q && stop_mid && accept && (mode != 2'b01 || !sm2_q);
    assign rb8_val = ninth;
    // Mode 0 samples the line at the end of each clock-high half
    assign rbuf_val = m0_done ? {s2_q, tsh_q[7:1]} : rdat;
  end
endmodule

// file: tb/dspam_checker.sv
`timescale 1ns/1ps
module dspam_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Serial lines
  input wire logic tx_line_0_o,
  input wire logic tx_line_1_o,
  input wire logic rx_line_0_oe_o,
  input wire logic rx_line_1_oe_o
);
  // ----
  // Helpers
  // ----
  logic rq;
  logic rd_wait;
  assign rq = avs_read_i || avs_write_i;
  assign rd_wait = avs_read_i && avs_waitrequest_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wait;
    rq && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    rq && !avs_waitrequest_o;
  endsequence
  // ----
  // Assertions
  // ----
  chk_wait_one: assert property (s_wait |=> !avs_waitrequest_o)
    else $error("waitrequest held longer than one cycle");
  chk_ack_single: assert property (s_ack ##1 rq |-> avs_waitrequest_o)
    else $error("new request acknowledged without a wait cycle");
  chk_wait_idle: assert property (!rq |-> !avs_waitrequest_o)
    else $error("waitrequest raised with no request");
  chk_rd_upper: assert property (s_ack and avs_read_i |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // Read data may only move at the edge that ends a read's wait cycle
  chk_rd_hold: assert property ($changed(avs_readdata_o) |-> $past(rd_wait))
    else $error("read data changed outside a read");
  chk_line_reset: assert property (disable iff (1'b0) rst_i |=>
    tx_line_0_o && tx_line_1_o && !rx_line_0_oe_o && !rx_line_1_oe_o)
    else $error("serial lines not idle after reset");
  chk_start_len0: assert property ($fell(tx_line_0_o) && !rx_line_0_oe_o |->
    !tx_line_0_o [*8])
    else $error("port 0 start bit too short");
  chk_start_len1: assert property ($fell(tx_line_1_o) && !rx_line_1_oe_o |->
    !tx_line_1_o [*8])
    else $error("port 1 start bit too short");
endmodule

// file: tb/dspam_node.sv
`timescale 1ns/1ps
module dspam_node (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic tx_i,
  output logic rx_o
);
  // Idle line rests high, as the port pin has a pull-up
  initial rx_o = 1'b1;
  task automatic send(input logic [8:0] v, input logic stp, input int blen);
    logic [10:0] f;
    f = {stp, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_o <= f[i];
      repeat (blen) @(posedge clk_i);
    end
    rx_o <= 1'b1;
  endtask
  // Samples mid-bit; a silent line gives up after a bounded wait
  task automatic recv(input int blen, output logic [8:0] v);
    int n;
    n = 0;
    while (tx_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (blen / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (blen) @(posedge clk_i);
      v[i] = tx_i;
    end
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dspam_pkg::*;
  logic clk_i, rst_i, avs_read_i, avs_write_i;
  logic [9:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0] avs_byteenable_i;
  logic avs_waitrequest_o, tx0, rx0, tx1, rx1, d0, oe0, d1, oe1, prev;
  int bad_count, compares, k, gap;
  logic [7:0] q, sh, lastgap;
  logic [8:0] fr;
  logic t1;
  // Timer 1 overflow every second clock: with doubling, 32 clocks per bit
  always @(posedge clk_i) t1 <= rst_i ? 1'b0 : ~t1;
  dspam_top i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .timer1_ovf_i(t1), .timer2_ovf_i(1'b0),
    .tx_line_0_o(tx0), .rx_line_0_i(rx0), .rx_line_0_o(d0), .rx_line_0_oe_o(oe0),
    .tx_line_1_o(tx1), .rx_line_1_i(rx1), .rx_line_1_o(d1), .rx_line_1_oe_o(oe1)
  );
  dspam_node i_node0 (.clk_i(clk_i), .tx_i(tx0), .rx_o(rx0));
  dspam_node i_node1 (.clk_i(clk_i), .tx_i(tx1), .rx_o(rx1));
  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) bad_count++;
    q = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(q & m, e);
  endtask
  // Loads mask and control, lets the node send one frame, then checks control
  task automatic rxc(input int p, input logic [7:0] cv, input logic [8:0] f, input logic s,
      input logic [7:0] mv, input logic [7:0] m, input logic [7:0] e);
    bus(1'b1, p ? IDX_MASK1 : IDX_MASK0, mv);
    bus(1'b1, p ? IDX_CTRL1 : IDX_CTRL0, cv);
    if (p) i_node1.send(f, s, 32);
    else i_node0.send(f, s, 64);
    repeat (4) @(posedge clk_i);
    rdc(p ? IDX_CTRL1 : IDX_CTRL0, m, e);
  endtask
  task automatic final_report;
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----
  // Clock, watchdog and sequence
  // ----
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
  initial begin
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 10'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    bad_count = 0;
    compares = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(IDX_CTRL0, 8'hff, 8'h00);
    rdc(8'h10, 8'hff, 8'h00);
    rdc(IDX_MASK1, 8'hff, 8'h00);
    // Mode 0 with fast clock: bits are taken at each rising shift clock
    bus(1'b1, IDX_CTRL0, 8'h20);
    bus(1'b1, IDX_BUF0, 8'h96);
    k = 0;
    gap = 0;
    prev = 1'b1;
    for (int n = 0; n < 400 && k < 8; n++) begin
      @(posedge clk_i);
      gap++;
      if (tx0 && !prev && oe0) begin
        sh = {d0, sh[7:1]};
        lastgap = 8'(gap);
        gap = 0;
        k++;
      end
      prev = tx0;
    end
    chk(sh, 8'h96);
    chk(lastgap, 8'h04);
    repeat (8) @(posedge clk_i);
    rdc(IDX_CTRL0, 8'h02, 8'h02);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, IDX_PWR, p ? 8'h80 : 8'h00);
      bus(1'b1, p ? IDX_CTRL1 : IDX_CTRL0, 8'h98);
      fork
        if (p) i_node1.recv(32, fr);
        else i_node0.recv(64, fr);
        bus(1'b1, p ? IDX_BUF1 : IDX_BUF0, 8'h5a);
      join
      chk(fr[7:0], 8'h5a);
      chk({7'h0, fr[8]}, 8'h01);
      repeat (40) @(posedge clk_i);
      rdc(p ? IDX_CTRL1 : IDX_CTRL0, 8'hff, 8'h9a);
      bus(1'b1, p ? IDX_ADDR1 : IDX_ADDR0, 8'h40);
      rxc(p, 8'h98, 9'h0c3, 1'b1, 8'h00, 8'hff, 8'h99);
      rdc(p ? IDX_BUF1 : IDX_BUF0, 8'hff, 8'hc3);
      rxc(p, 8'hb8, 9'h011, 1'b1, 8'h00, 8'h07, 8'h00);
      rxc(p, 8'hb8, 9'h14f, 1'b1, 8'hf0, 8'h03, 8'h01);
      rdc(p ? IDX_BUF1 : IDX_BUF0, 8'hff, 8'h4f);
      rxc(p, 8'hb8, 9'h15f, 1'b1, 8'hf0, 8'h03, 8'h00);
      rxc(p, 8'hb8, 9'h177, 1'b1, 8'h00, 8'h03, 8'h01);
      rxc(p, 8'h88, 9'h122, 1'b1, 8'h00, 8'h03, 8'h00);
      rdc(p ? IDX_BUF1 : IDX_BUF0, 8'hff, 8'h77);
      // Top control bit now reads as the stop error; mode bit is kept apart
      bus(1'b1, IDX_PWR, p ? 8'hc0 : 8'h40);
      rxc(p, 8'h18, 9'h033, 1'b0, 8'h00, 8'h80, 8'h80);
      bus(1'b1, p ? IDX_CTRL1 : IDX_CTRL0, 8'h18);
      rdc(p ? IDX_CTRL1 : IDX_CTRL0, 8'h80, 8'h00);
    end
    // Mode 1 on port 1, rate from timer 1 with doubling on
    bus(1'b1, IDX_PWR, 8'h80);
    rxc(1, 8'h70, 9'h0a5, 1'b0, 8'h00, 8'h01, 8'h00);
    rxc(1, 8'h50, 9'h1a5, 1'b1, 8'h00, 8'h05, 8'h05);
    rdc(IDX_BUF1, 8'hff, 8'ha5);
    final_report();
  end
endmodule
bind dspam_top dspam_checker i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .tx_line_0_o(tx_line_0_o), .tx_line_1_o(tx_line_1_o),
  .rx_line_0_oe_o(rx_line_0_oe_o), .rx_line_1_oe_o(rx_line_1_oe_o)
);
